// ### logic/usbie_endpoint.sv
module usbie_endpoint
  import usbie_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wr_stb,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] wr_mask,
  input wire logic fifo_hold,
  input wire logic ev_setup,
  input wire logic ev_bank_a,
  input wire logic ev_bank_b,
  input wire logic ev_tx_acked,
  input wire logic ev_stall_acked,
  input wire logic ev_tx_sent,
  input wire logic ev_toggle,
  input wire logic [usbie_pkg::USBIE_COUNT_W-1:0] rx_count,
  output logic [31:0] csr_word,
  output logic irq_req,
  output logic stall_request,
  output logic tx_packet_loaded,
  output logic endpoint_on
);

  typedef struct packed {
    logic on;
    logic toggle;
    logic [2:0] kind;
    logic dir;
    logic bank_b;
    logic stall_req;
    logic loaded;
    logic stall_ack;
    logic setup;
    logic bank_a;
    logic tx_ack;
  } usbie_ep_state_t;

  usbie_ep_state_t st_reg;
  usbie_ep_state_t st_next;

  function automatic logic cleared(input int pos, input logic stb, input logic [31:0] d,
                                   input logic [31:0] m);
    cleared = stb & m[pos] & ~d[pos];
  endfunction

  function automatic logic upd(input int pos, input logic old, input logic stb,
                               input logic [31:0] d, input logic [31:0] m);
    upd = (stb & m[pos]) ? d[pos] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.on = upd(USBIE_F_ON, st_reg.on, wr_stb, wr_data, wr_mask);
    st_next.kind = (wr_stb & wr_mask[USBIE_F_KIND_LSB]) ?
                   wr_data[USBIE_F_KIND_LSB +: 3] : st_reg.kind;
    st_next.dir = upd(USBIE_F_DIR, st_reg.dir, wr_stb, wr_data, wr_mask);
    st_next.stall_req = upd(USBIE_F_STALL_REQ, st_reg.stall_req, wr_stb, wr_data, wr_mask);
    // Hardware-set flags: an event in the clearing cycle wins over the clear.
    st_next.tx_ack = ev_tx_acked |
                     (st_reg.tx_ack & ~cleared(USBIE_F_TX_ACK, wr_stb, wr_data, wr_mask));
    st_next.setup = ev_setup |
                    (st_reg.setup & ~cleared(USBIE_F_SETUP, wr_stb, wr_data, wr_mask));
    st_next.bank_a = ev_bank_a |
                     (st_reg.bank_a & ~cleared(USBIE_F_BANK_A, wr_stb, wr_data, wr_mask));
    st_next.bank_b = ev_bank_b |
                     (st_reg.bank_b & ~cleared(USBIE_F_BANK_B, wr_stb, wr_data, wr_mask));
    st_next.stall_ack = ev_stall_acked |
                        (st_reg.stall_ack &
                         ~cleared(USBIE_F_STALL_ACK, wr_stb, wr_data, wr_mask));
    // Software may only load a packet; the engine clears it once sent.
    if (wr_stb & wr_mask[USBIE_F_LOADED] & wr_data[USBIE_F_LOADED]) begin
      st_next.loaded = 1'b1;
    end else if (ev_tx_sent) begin
      st_next.loaded = 1'b0;
    end
    if (fifo_hold) begin
      st_next.toggle = 1'b0;
    end else if (ev_toggle) begin
      st_next.toggle = ~st_reg.toggle;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    csr_word = '0;
    csr_word[USBIE_F_COUNT_LSB +: USBIE_COUNT_W] = fifo_hold ? '0 : rx_count;
    csr_word[USBIE_F_ON] = st_reg.on | (st_reg.kind == USBIE_KIND_CONTROL);
    csr_word[USBIE_F_TOGGLE] = st_reg.toggle;
    csr_word[USBIE_F_KIND_LSB +: 3] = st_reg.kind;
    csr_word[USBIE_F_DIR] = st_reg.dir;
    csr_word[USBIE_F_BANK_B] = st_reg.bank_b;
    csr_word[USBIE_F_STALL_REQ] = st_reg.stall_req;
    csr_word[USBIE_F_LOADED] = st_reg.loaded;
    csr_word[USBIE_F_STALL_ACK] = st_reg.stall_ack;
    csr_word[USBIE_F_SETUP] = st_reg.setup;
    csr_word[USBIE_F_BANK_A] = st_reg.bank_a;
    csr_word[USBIE_F_TX_ACK] = st_reg.tx_ack;
  end

  assign irq_req = st_reg.setup | st_reg.bank_a | st_reg.bank_b | st_reg.tx_ack |
                   st_reg.stall_ack;
  assign stall_request = st_reg.stall_req;
  assign tx_packet_loaded = st_reg.loaded;
  assign endpoint_on = st_reg.on;

endmodule

// ### logic/usbie_pkg.sv
package usbie_pkg;

  localparam int USBIE_EP_N = 6;
  localparam int USBIE_COUNT_W = 11;
  localparam int USBIE_ADR_W = 8;

  // Timing: bus idle time before suspend, and the system clock rate.
  localparam int USBIE_CLK_HZ = 25_000_000;
  localparam int USBIE_SUSPEND_IDLE_MS = 3;
  localparam int USBIE_SUSPEND_IDLE_CYC = USBIE_SUSPEND_IDLE_MS * (USBIE_CLK_HZ / 1000);
  localparam int USBIE_IDLE_CNT_W = 17;

  // Register byte offsets.
  localparam logic [7:0] USBIE_OFS_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] USBIE_OFS_IRQ_DISABLE = 8'h14;
  localparam logic [7:0] USBIE_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] USBIE_OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] USBIE_OFS_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] USBIE_OFS_FIFO_RESET = 8'h28;
  localparam logic [7:0] USBIE_OFS_CSR_BASE = 8'h30;

  // Interrupt register bit positions; bits 0..5 are the endpoints.
  localparam int USBIE_BIT_SUSPEND = 8;
  localparam int USBIE_BIT_RESUME = 9;
  localparam int USBIE_BIT_FRAME = 11;
  localparam int USBIE_BIT_BUS_RESET = 12;
  localparam int USBIE_BIT_WAKEUP = 13;

  // Endpoint control/status field positions.
  localparam int USBIE_F_COUNT_LSB = 16;
  localparam int USBIE_F_ON = 15;
  localparam int USBIE_F_TOGGLE = 11;
  localparam int USBIE_F_KIND_LSB = 8;
  localparam int USBIE_F_DIR = 7;
  localparam int USBIE_F_BANK_B = 6;
  localparam int USBIE_F_STALL_REQ = 5;
  localparam int USBIE_F_LOADED = 4;
  localparam int USBIE_F_STALL_ACK = 3;
  localparam int USBIE_F_SETUP = 2;
  localparam int USBIE_F_BANK_A = 1;
  localparam int USBIE_F_TX_ACK = 0;

  // Reset values.
  localparam logic USBIE_RST_MASK_RESUME = 1'b1;
  localparam logic [5:0] USBIE_RST_MASK_EP = 6'h00;
  localparam logic [2:0] USBIE_KIND_CONTROL = 3'h0;

endpackage

// ### logic/usbie_regs.sv
// Notes on behaviour
// - Writing one to a disable bit clears that interrupt's mask bit.
// - Writing one to an enable bit sets that interrupt's mask bit.
// - Mask register reads one for each enabled source, zero otherwise.
// - Mask bit 12 cannot be masked and always reads one.
// - Resume interrupt is enabled after reset.
// - Endpoint status rises on setup, either bank full, tx acked or stall acked.
// - Endpoint status stays until its source flag is cleared in its register.
// - After 3 ms of bus silence, flag suspend and enter suspend mode.
// - Detected resume signalling sets the resume status bit.
// - Every start-of-frame token sets the frame-start status bit.
// - End of a bus reset sets its status bit; endpoint zero is then ready (here bus_reset_done only sets the status bit; no endpoint sees it).
// - Wakeup status sets on resume or reset signalling since last clear.
// - Writing one to a clear bit clears that status bit.
// - While endpoint reset is one, its FIFO pointers and count stay zero.
// - Endpoint reset returns the data toggle to DATA0.
// - Software drops endpoint reset itself; endpoint flags are left untouched.
// - Endpoint register layout: count, enable, toggle, kind, then eight flags.
// - Host acknowledge sets tx acked; writing zero clears it, one does nothing.
// - While tx acked is one, the endpoint interrupt request stays asserted.
//
// The address map and the Wishbone slave port were left to the implementer.
module usbie_regs
  import usbie_pkg::*;
#(
  parameter int SUSPEND_IDLE_CYCLES = usbie_pkg::USBIE_SUSPEND_IDLE_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [usbie_pkg::USBIE_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_activity,
  input wire logic resume_seen,
  input wire logic bus_reset_seen,
  input wire logic bus_reset_done,
  input wire logic frame_start_seen,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_setup_received,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_rx_bank_a_full,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_rx_bank_b_full,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_acked,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_stall_acked,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_sent,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_toggle_flip,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0][usbie_pkg::USBIE_COUNT_W-1:0] ep_received_count,
  output logic usb_irq,
  output logic suspend_mode,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_fifo_hold,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_stall_request,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_packet_loaded,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_endpoint_on
);

  typedef struct packed {
    logic [USBIE_EP_N-1:0] mask_ep;
    logic mask_suspend;
    logic mask_resume;
    logic mask_frame;
    logic mask_wakeup;
    logic suspend_irq;
    logic resume_irq;
    logic frame_start_irq;
    logic bus_reset_done_irq;
    logic wakeup_irq;
    logic [USBIE_IDLE_CNT_W-1:0] idle_cnt;
    logic suspended;
    logic [USBIE_EP_N-1:0] fifo_hold;
    logic ack;
    logic [31:0] rdata;
    logic irq;
  } usbie_state_t;

  usbie_state_t st_reg;
  usbie_state_t st_next;

  logic [USBIE_EP_N-1:0][31:0] ep_word;
  logic [USBIE_EP_N-1:0] ep_irq;
  logic [USBIE_EP_N-1:0] ep_wr;
  logic [31:0] lane_mask;
  logic [31:0] wdata;
  logic access;
  logic write;
  logic [31:0] status_word;
  logic [31:0] mask_word;

  // Decodes an endpoint register address: hit flag above a three-bit index.
  function automatic logic [3:0] csr_slot(input logic [USBIE_ADR_W-1:0] adr);
    logic [USBIE_ADR_W-1:0] rel;
    rel = adr - USBIE_OFS_CSR_BASE;
    csr_slot = '0;
    if (adr >= USBIE_OFS_CSR_BASE && rel[1:0] == 2'b00 &&
        rel[USBIE_ADR_W-1:2] < (USBIE_ADR_W - 2)'(USBIE_EP_N)) begin
      csr_slot = {1'b1, rel[4:2]};
    end
  endfunction

  function automatic logic [31:0] sel_to_mask(input logic [3:0] sel);
    sel_to_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave strobes. The answer comes one cycle after the request is seen.
  assign access = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign write = access & wb_we_i;
  assign lane_mask = sel_to_mask(wb_sel_i);
  assign wdata = wb_dat_i & lane_mask;

  always_comb begin
    logic [3:0] slot;
    slot = csr_slot(wb_adr_i);
    ep_wr = '0;
    if (write && slot[3]) begin
      ep_wr[slot[2:0]] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Endpoints.
  for (genvar i = 0; i < USBIE_EP_N; i++) begin : g_ep
    usbie_endpoint u_ep (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .wr_stb(ep_wr[i]),
      .wr_data(wb_dat_i),
      .wr_mask(lane_mask),
      .fifo_hold(st_reg.fifo_hold[i]),
      .ev_setup(ep_setup_received[i]),
      .ev_bank_a(ep_rx_bank_a_full[i]),
      .ev_bank_b(ep_rx_bank_b_full[i]),
      .ev_tx_acked(ep_tx_acked[i]),
      .ev_stall_acked(ep_stall_acked[i]),
      .ev_tx_sent(ep_tx_sent[i]),
      .ev_toggle(ep_toggle_flip[i]),
      .rx_count(ep_received_count[i]),
      .csr_word(ep_word[i]),
      .irq_req(ep_irq[i]),
      .stall_request(ep_stall_request[i]),
      .tx_packet_loaded(ep_tx_packet_loaded[i]),
      .endpoint_on(ep_endpoint_on[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read views of the interrupt registers.
  always_comb begin
    status_word = '0;
    status_word[USBIE_EP_N-1:0] = ep_irq;
    status_word[USBIE_BIT_SUSPEND] = st_reg.suspend_irq;
    status_word[USBIE_BIT_RESUME] = st_reg.resume_irq;
    status_word[USBIE_BIT_FRAME] = st_reg.frame_start_irq;
    status_word[USBIE_BIT_BUS_RESET] = st_reg.bus_reset_done_irq;
    status_word[USBIE_BIT_WAKEUP] = st_reg.wakeup_irq;
    mask_word = '0;
    mask_word[USBIE_EP_N-1:0] = st_reg.mask_ep;
    mask_word[USBIE_BIT_SUSPEND] = st_reg.mask_suspend;
    mask_word[USBIE_BIT_RESUME] = st_reg.mask_resume;
    mask_word[USBIE_BIT_FRAME] = st_reg.mask_frame;
    mask_word[USBIE_BIT_BUS_RESET] = 1'b1;
    mask_word[USBIE_BIT_WAKEUP] = st_reg.mask_wakeup;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] set_w;
    logic [31:0] dis_w;
    logic [31:0] clr_w;
    logic [3:0] slot;
    st_next = st_reg;
    slot = csr_slot(wb_adr_i);
    set_w = (write && wb_adr_i == USBIE_OFS_IRQ_ENABLE) ? wdata : '0;
    dis_w = (write && wb_adr_i == USBIE_OFS_IRQ_DISABLE) ? wdata : '0;
    clr_w = (write && wb_adr_i == USBIE_OFS_IRQ_CLEAR) ? wdata : '0;

    // Mask: enabling wins over disabling when both land together.
    st_next.mask_ep = (st_reg.mask_ep & ~dis_w[USBIE_EP_N-1:0]) |
                      set_w[USBIE_EP_N-1:0];
    st_next.mask_suspend = (st_reg.mask_suspend & ~dis_w[USBIE_BIT_SUSPEND]) |
                           set_w[USBIE_BIT_SUSPEND];
    st_next.mask_resume = (st_reg.mask_resume & ~dis_w[USBIE_BIT_RESUME]) |
                          set_w[USBIE_BIT_RESUME];
    st_next.mask_frame = (st_reg.mask_frame & ~dis_w[USBIE_BIT_FRAME]) |
                         set_w[USBIE_BIT_FRAME];
    st_next.mask_wakeup = (st_reg.mask_wakeup & ~dis_w[USBIE_BIT_WAKEUP]) |
                          set_w[USBIE_BIT_WAKEUP];

    // Suspend detection: a long idle timer restarted by any bus activity.
    if (bus_activity) begin
      st_next.idle_cnt = '0;
      st_next.suspended = 1'b0;
    end else if (!st_reg.suspended) begin
      if (st_reg.idle_cnt == USBIE_IDLE_CNT_W'(SUSPEND_IDLE_CYCLES - 1)) begin
        st_next.suspended = 1'b1;
      end else begin
        st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
      end
    end

    // Sticky status: a set in the clearing cycle wins over the clear.
    st_next.suspend_irq = (st_next.suspended & ~st_reg.suspended) |
                          (st_reg.suspend_irq & ~clr_w[USBIE_BIT_SUSPEND]);
    st_next.resume_irq = resume_seen |
                         (st_reg.resume_irq & ~clr_w[USBIE_BIT_RESUME]);
    st_next.frame_start_irq = frame_start_seen |
                              (st_reg.frame_start_irq & ~clr_w[USBIE_BIT_FRAME]);
    st_next.bus_reset_done_irq = bus_reset_done |
                                 (st_reg.bus_reset_done_irq &
                                  ~clr_w[USBIE_BIT_BUS_RESET]);
    st_next.wakeup_irq = resume_seen | bus_reset_seen |
                         (st_reg.wakeup_irq & ~clr_w[USBIE_BIT_WAKEUP]);

    // Endpoint reset is a plain level; software must drop it again.
    if (write && wb_adr_i == USBIE_OFS_FIFO_RESET) begin
      st_next.fifo_hold = (st_reg.fifo_hold & ~lane_mask[USBIE_EP_N-1:0]) |
                          wdata[USBIE_EP_N-1:0];
    end

    // Bus answer; unmapped reads return zero and unmapped writes are dropped.
    st_next.ack = access;
    st_next.rdata = '0;
    if (access && !wb_we_i) begin
      if (slot[3]) begin
        st_next.rdata = ep_word[slot[2:0]];
      end else if (wb_adr_i == USBIE_OFS_IRQ_MASK) begin
        st_next.rdata = mask_word;
      end else if (wb_adr_i == USBIE_OFS_IRQ_STATUS) begin
        st_next.rdata = status_word;
      end else if (wb_adr_i == USBIE_OFS_FIFO_RESET) begin
        st_next.rdata = {{(32 - USBIE_EP_N){1'b0}}, st_reg.fifo_hold};
      end
    end

    // The request line follows the registered views, so it lags one cycle.
    st_next.irq = |(status_word & mask_word);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.mask_ep <= USBIE_RST_MASK_EP;
      st_reg.mask_resume <= USBIE_RST_MASK_RESUME;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign usb_irq = st_reg.irq;
  assign suspend_mode = st_reg.suspended;
  assign ep_fifo_hold = st_reg.fifo_hold;

endmodule

// ### testbench/testbench.sv
module testbench;
  import usbie_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE_P = 20;
  logic ref_clk;
  logic resetn;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic bus_activity;
  logic resume_seen;
  logic bus_reset_seen;
  logic bus_reset_done;
  logic frame_start_seen;
  logic [USBIE_EP_N-1:0] ep_setup_received, ep_rx_bank_a_full, ep_rx_bank_b_full, ep_tx_acked;
  logic [USBIE_EP_N-1:0] ep_stall_acked, ep_tx_sent, ep_toggle_flip, ep_fifo_hold;
  logic [USBIE_EP_N-1:0] ep_stall_request, ep_tx_packet_loaded, ep_endpoint_on;
  logic [USBIE_EP_N-1:0][USBIE_COUNT_W-1:0] ep_received_count;
  logic usb_irq;
  logic suspend_mode;
  logic host_quiet;
  logic [31:0] rd;
  logic [7:0] csr;
  logic [31:0] ce;
  int miscompares;
  int samples_checked;
  int i;
  logic [31:0] ev_exp [4] = '{32'h0000_0800, 32'h0000_2200, 32'h0000_2000, 32'h0000_1000};
  int fbit [5] = '{USBIE_F_SETUP, USBIE_F_BANK_A, USBIE_F_BANK_B, USBIE_F_TX_ACK, USBIE_F_STALL_ACK};

  usbie_regs #(.SUSPEND_IDLE_CYCLES(IDLE_P)) u_usbie_regs (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_activity(bus_activity),
    .resume_seen(resume_seen), .bus_reset_seen(bus_reset_seen),
    .bus_reset_done(bus_reset_done), .frame_start_seen(frame_start_seen),
    .ep_setup_received(ep_setup_received), .ep_rx_bank_a_full(ep_rx_bank_a_full),
    .ep_rx_bank_b_full(ep_rx_bank_b_full), .ep_tx_acked(ep_tx_acked),
    .ep_stall_acked(ep_stall_acked), .ep_tx_sent(ep_tx_sent), .ep_toggle_flip(ep_toggle_flip),
    .ep_received_count(ep_received_count), .usb_irq(usb_irq), .suspend_mode(suspend_mode),
    .ep_fifo_hold(ep_fifo_hold), .ep_stall_request(ep_stall_request),
    .ep_tx_packet_loaded(ep_tx_packet_loaded), .ep_endpoint_on(ep_endpoint_on));
  usbie_host_model u_usbie_host_model (
    .ref_clk(ref_clk), .host_quiet(host_quiet), .bus_activity(bus_activity),
    .resume_seen(resume_seen), .bus_reset_seen(bus_reset_seen),
    .bus_reset_done(bus_reset_done), .frame_start_seen(frame_start_seen),
    .ep_setup_received(ep_setup_received), .ep_rx_bank_a_full(ep_rx_bank_a_full),
    .ep_rx_bank_b_full(ep_rx_bank_b_full), .ep_tx_acked(ep_tx_acked),
    .ep_stall_acked(ep_stall_acked), .ep_tx_sent(ep_tx_sent), .ep_toggle_flip(ep_toggle_flip));

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // The request stays put until ack is seen at an edge; only then is it dropped.
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(1'h1, adr, dat);
  endtask
  task automatic rdc(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'h0, adr, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    host_quiet = 1'h0;
    miscompares = 0;
    samples_checked = 0;
    for (i = 0; i < USBIE_EP_N; i++) ep_received_count[i] = 11'h120 + 11'(i);
    wait_clk(6);
    resetn <= 1'h1;
    rdc("mask_reset", USBIE_OFS_IRQ_MASK, 32'h0000_1200);
    rdc("unmapped", 8'h04, 32'h0000_0000);
    wr(USBIE_OFS_IRQ_CLEAR, 32'h0000_3B00);
    rdc("status_clear", USBIE_OFS_IRQ_STATUS, 32'h0000_0000);
    wr(USBIE_OFS_IRQ_ENABLE, 32'h0000_2B3F);
    rdc("mask_enable", USBIE_OFS_IRQ_MASK, 32'h0000_3B3F);
    wr(USBIE_OFS_IRQ_DISABLE, 32'h0000_0000);
    rdc("mask_zero_write", USBIE_OFS_IRQ_MASK, 32'h0000_3B3F);
    wr(USBIE_OFS_IRQ_DISABLE, 32'h0000_1A15);
    rdc("mask_disable", USBIE_OFS_IRQ_MASK, 32'h0000_312A);
    for (i = 0; i < 4; i++) begin
      u_usbie_host_model.send(i, 0);
      rdc("event_status", USBIE_OFS_IRQ_STATUS, ev_exp[i]);
      check("event_irq", 32'(usb_irq), 32'((ev_exp[i] & 32'h0000_312A) != 0));
      wr(USBIE_OFS_IRQ_CLEAR, 32'h0000_3B00);
      wait_clk(2);
      rdc("event_cleared", USBIE_OFS_IRQ_STATUS, 32'h0000_0000);
      check("event_irq_off", 32'(usb_irq), 32'h0000_0000);
    end
    wr(USBIE_OFS_IRQ_ENABLE, 32'h0000_003F);
    for (i = 0; i < 5; i++) begin
      csr = USBIE_OFS_CSR_BASE + 8'(4 * i);
      ce = {5'h00, ep_received_count[i], 16'h8000};
      if (i == 3) wr(csr, 32'h0000_0010);
      u_usbie_host_model.send(4 + i, i);
      rdc("ep_status", USBIE_OFS_IRQ_STATUS, 32'h0000_0001 << i);
      check("ep_irq", 32'(usb_irq), 32'h0000_0001);
      rdc("ep_csr", csr, ce | (32'h0000_0001 << fbit[i]));
      wr(csr, 32'h0000_806F);
      rdc("ep_keep", csr, ce | (32'h0000_0001 << fbit[i]) | 32'h0000_0020);
      check("ep_on", 32'(ep_endpoint_on), 32'h0000_0001 << i);
      wr(csr, 32'h0000_0000);
      rdc("ep_cleared", csr, ce);
      wait_clk(2);
      check("ep_irq_off", 32'(usb_irq), 32'h0000_0000);
    end
    ce = {5'h00, ep_received_count[0], 16'h8004};
    u_usbie_host_model.send(9, 0);
    u_usbie_host_model.send(4, 0);
    rdc("toggle_set", USBIE_OFS_CSR_BASE, ce | 32'h0000_0800);
    wr(USBIE_OFS_FIFO_RESET, 32'h0000_0001);
    rdc("fifo_reset", USBIE_OFS_FIFO_RESET, 32'h0000_0001);
    rdc("ep_held", USBIE_OFS_CSR_BASE, 32'h0000_8004);
    wr(USBIE_OFS_FIFO_RESET, 32'h0000_0000);
    rdc("ep_released", USBIE_OFS_CSR_BASE, ce);
    wr(USBIE_OFS_CSR_BASE, 32'h0000_0000);
    @(posedge ref_clk);
    host_quiet <= 1'h1;
    wait_clk(IDLE_P + 4);
    check("suspend_on", 32'(suspend_mode), 32'h0000_0001);
    rdc("suspend_status", USBIE_OFS_IRQ_STATUS, 32'h0000_0100);
    @(posedge ref_clk);
    host_quiet <= 1'h0;
    wait_clk(2);
    check("suspend_off", 32'(suspend_mode), 32'h0000_0000);
    test_done();
  end
  initial begin
    wait_clk(5000);
    miscompares++;
    test_done();
  end
endmodule

// ### testbench/usbie_assertions.sv
module usbie_assertions
  import usbie_pkg::*;
#(
  parameter int SUSPEND_IDLE_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_we_i,
  input wire logic [usbie_pkg::USBIE_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic bus_activity,
  input wire logic bus_reset_done,
  input wire logic usb_irq,
  input wire logic suspend_mode,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_fifo_hold,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_stall_request,
  input wire logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_packet_loaded
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic [16:0] idle_cnt;
  logic rd_ack;
  logic wr_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  // A window allows for where the design starts counting.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 17'h0_0000;
    end else if (bus_activity) begin
      idle_cnt <= 17'h0_0000;
    end else if (idle_cnt != 17'h1_FFFF) begin
      idle_cnt <= idle_cnt + 17'h0_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_mask_bit12: assert property (rd_ack && wb_adr_i == USBIE_OFS_IRQ_MASK |-> wb_dat_o[12])
    else $error("mask bit 12 read as zero");
  a_reset_done_irq: assert property (bus_reset_done |-> ##2 usb_irq)
    else $error("bus reset done did not raise the interrupt");
  a_suspend_window: assert property ($rose(suspend_mode) |->
    int'(idle_cnt) >= SUSPEND_IDLE_CYCLES - 1 && int'(idle_cnt) <= SUSPEND_IDLE_CYCLES + 2)
    else $error("suspend entered at the wrong idle time");
  a_activity_wakes: assert property (bus_activity |=> !suspend_mode)
    else $error("suspend held through bus activity");
  a_hold_count: assert property (rd_ack && wb_adr_i == USBIE_OFS_CSR_BASE
    && ep_fifo_hold[0] |-> wb_dat_o[26:16] == 11'h000)
    else $error("count not zero while endpoint reset held");
  a_hold_write: assert property (wr_ack && wb_adr_i == USBIE_OFS_FIFO_RESET
    |=> ep_fifo_hold == $past(wb_dat_i[5:0]))
    else $error("endpoint reset bits do not follow the write");
  a_stall_write: assert property (wr_ack && wb_adr_i == USBIE_OFS_CSR_BASE
    |=> ep_stall_request[0] == $past(wb_dat_i[5]))
    else $error("stall request does not follow the write");
  a_loaded_set: assert property (wr_ack && wb_adr_i == 8'h3C && wb_dat_i[4]
    |=> ep_tx_packet_loaded[3])
    else $error("packet loaded flag not set by write");
  c_suspend: cover property ($rose(suspend_mode));
  c_irq: cover property ($rose(usb_irq));
  c_hold_read: cover property (rd_ack && ep_fifo_hold[0]);
endmodule

bind usbie_regs usbie_assertions #(.SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)) u_usbie_assertions (
  .ref_clk(ref_clk), .resetn(resetn), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bus_activity(bus_activity), .bus_reset_done(bus_reset_done), .usb_irq(usb_irq),
  .suspend_mode(suspend_mode), .ep_fifo_hold(ep_fifo_hold),
  .ep_stall_request(ep_stall_request), .ep_tx_packet_loaded(ep_tx_packet_loaded)
);

// ### testbench/usbie_host_model.sv
module usbie_host_model
  import usbie_pkg::*;
(
  input wire logic ref_clk,
  input wire logic host_quiet,
  output logic bus_activity,
  output logic resume_seen,
  output logic bus_reset_seen,
  output logic bus_reset_done,
  output logic frame_start_seen,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_setup_received,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_rx_bank_a_full,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_rx_bank_b_full,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_acked,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_stall_acked,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_tx_sent,
  output logic [usbie_pkg::USBIE_EP_N-1:0] ep_toggle_flip
);
  timeunit 1ns;
  timeprecision 1ns;
  // A quiet host stops all traffic, which is what lets the idle timer run out.
  assign bus_activity = !host_quiet;
  task automatic clear_all();
    {resume_seen, bus_reset_seen, bus_reset_done, frame_start_seen} <= 4'h0;
    {ep_setup_received, ep_rx_bank_a_full, ep_rx_bank_b_full, ep_tx_acked} <= 24'h00_0000;
    {ep_stall_acked, ep_tx_sent, ep_toggle_flip} <= 18'h0_0000;
  endtask
  initial begin
    clear_all();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Every event is a single cycle pulse; a held pulse would hide set-versus-clear races.
  task automatic send(input int code, input int ep);
    logic [USBIE_EP_N-1:0] b;
    b = 6'h01 << ep;
    @(posedge ref_clk);
    case (code)
      0: frame_start_seen <= 1'h1;
      1: resume_seen <= 1'h1;
      2: bus_reset_seen <= 1'h1;
      3: bus_reset_done <= 1'h1;
      4: ep_setup_received <= b;
      5: ep_rx_bank_a_full <= b;
      6: ep_rx_bank_b_full <= b;
      7: begin
        ep_tx_acked <= b;
        ep_tx_sent <= b;
      end
      8: ep_stall_acked <= b;
      default: ep_toggle_flip <= b;
    endcase
    @(posedge ref_clk);
    clear_all();
  endtask
endmodule
